// >>> riost_pins.sv
// Rear status pin and trigger pin logic with register port
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module riost_pins
    import riost_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic output_on,
    input wire logic meter_trig,
    input wire logic dlog_trig,
    input wire logic seq_trig,
    input wire logic status_pin_in,
    output logic status_pin_out,
    output logic status_pin_oe,
    input wire logic trig_pin_in,
    output logic trig_pin_out,
    output logic trig_pin_oe,
    output logic meter_start,
    output logic dlog_start,
    output logic seq_start,
    output logic irq
);

    typedef struct packed {
        logic [7:0] stat_cfg;
        logic [7:0] trig_cfg;
        logic [CNT_W-1:0] pwm_period;
        logic [CNT_W-1:0] pwm_high;
        logic meter_armed;
        logic seq_ext;
        logic [1:0] stat_sync;
        logic [1:0] trig_sync;
        logic [CNT_W-1:0] in_cnt;
        logic in_done;
        riost_pulse_e out_state;
        logic [CNT_W-1:0] out_cnt;
        logic trig_drive;
        logic stat_drive;
        logic meter_go;
        logic dlog_go;
        logic seq_go;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic [31:0] rdata;
    } riost_state_s;

    riost_state_s st_r;
    riost_state_s st_nxt;
    logic pwm_level;

    // Logical value to pin level: true is low unless inverted
    function automatic logic to_pin(input logic val, input logic inv);
        return ~val ^ inv;
    endfunction

    // Level picked for a general output source
    function automatic logic gen_src(input logic [1:0] src, input logic pwm);
        if (src == SRC_ONE) begin
            return 1'b1;
        end else if (src == SRC_ZERO) begin
            return 1'b0;
        end
        return pwm;
    endfunction

    riost_pwm u_pwm (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .period(st_r.pwm_period),
        .high_len(st_r.pwm_high),
        .pwm_out(pwm_level)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic trig_active;
        logic any_trig;
        logic [1:0] sfunc;
        logic [1:0] tfunc;
        logic trig_in_mode;
        logic [IRQ_W-1:0] ev;
        trig_active = 1'b0;
        any_trig = 1'b0;
        sfunc = st_r.stat_cfg[F_FUNC +: 2];
        tfunc = st_r.trig_cfg[F_FUNC +: 2];
        trig_in_mode = 1'b0;
        ev = '0;
        st_nxt = st_r;
        st_nxt.meter_go = 1'b0;
        st_nxt.dlog_go = 1'b0;
        st_nxt.seq_go = 1'b0;
        st_nxt.rdata = 32'h0000_0000;

        // Both pin inputs pass two flip-flops before use
        st_nxt.stat_sync = {st_r.stat_sync[0], status_pin_in};
        st_nxt.trig_sync = {st_r.trig_sync[0], trig_pin_in};

        // Status pin drive level
        if (sfunc == FUNC_DEFAULT) begin
            st_nxt.stat_drive = to_pin(output_on, st_r.stat_cfg[F_INV]);
        end else begin
            st_nxt.stat_drive = to_pin(gen_src(st_r.stat_cfg[F_SRC +: 2], pwm_level),
                st_r.stat_cfg[F_INV]);
        end

        // Trigger output pulse: low phase held for the full count
        any_trig = meter_trig | dlog_trig | seq_trig;
        case (st_r.out_state)
            RIOST_IDLE: begin
                if (any_trig && tfunc == FUNC_DEFAULT && !st_r.trig_cfg[F_DIR]) begin
                    st_nxt.out_state = RIOST_LOW;
                    st_nxt.out_cnt = '0;
                    ev[IRQ_TRIG_OUT] = 1'b1;
                end
            end
            RIOST_LOW: begin
                trig_active = 1'b1;
                if (st_r.out_cnt == CNT_W'(TRIG_LOW_CYC - 1)) begin
                    st_nxt.out_state = RIOST_HIGH;
                    st_nxt.out_cnt = '0;
                end else begin
                    st_nxt.out_cnt = st_r.out_cnt + 16'h0001;
                end
            end
            RIOST_HIGH: begin
                // Idle phase of equal length keeps pulses distinct
                if (st_r.out_cnt == CNT_W'(TRIG_LOW_CYC - 1)) begin
                    st_nxt.out_state = RIOST_IDLE;
                end else begin
                    st_nxt.out_cnt = st_r.out_cnt + 16'h0001;
                end
            end
            default: begin
                st_nxt.out_state = RIOST_IDLE;
            end
        endcase

        // Trigger pin drive level
        if (tfunc == FUNC_DEFAULT) begin
            // Idle level is high, active phase low unless inverted
            st_nxt.trig_drive = ~trig_active ^ st_r.trig_cfg[F_INV];
        end else begin
            st_nxt.trig_drive = to_pin(gen_src(st_r.trig_cfg[F_SRC +: 2], pwm_level),
                st_r.trig_cfg[F_INV]);
        end

        // Input qualifier: active phase of at least the minimum width
        trig_in_mode = (tfunc == FUNC_DEFAULT) && st_r.trig_cfg[F_DIR];
        if (trig_in_mode && (~st_r.trig_sync[1] ^ st_r.trig_cfg[F_INV])) begin
            if (st_r.in_cnt != CNT_W'(TRIG_LOW_CYC - 1)) begin
                st_nxt.in_cnt = st_r.in_cnt + 16'h0001;
            end else if (!st_r.in_done) begin
                st_nxt.in_done = 1'b1; // One event per pulse
                ev[IRQ_TRIG_IN] = 1'b1;
                case (st_r.trig_cfg[F_TGT +: 2])
                    TGT_METER: begin
                        st_nxt.meter_go = st_r.meter_armed;
                        st_nxt.meter_armed = 1'b0;
                    end
                    TGT_DLOG: begin
                        st_nxt.dlog_go = 1'b1;
                    end
                    TGT_SEQ: begin
                        st_nxt.seq_go = st_r.seq_ext;
                    end
                    default: begin
                    end
                endcase
            end
        end else begin
            st_nxt.in_cnt = '0;
            st_nxt.in_done = 1'b0;
        end

        // Register writes
        if (reg_wr) begin
            if (reg_addr == REG_STAT_CFG) begin
                st_nxt.stat_cfg = reg_wdata[7:0];
            end else if (reg_addr == REG_TRIG_CFG) begin
                st_nxt.trig_cfg = reg_wdata[7:0];
            end else if (reg_addr == REG_PWM_PERIOD) begin
                st_nxt.pwm_period = reg_wdata[CNT_W-1:0];
            end else if (reg_addr == REG_PWM_HIGH) begin
                st_nxt.pwm_high = reg_wdata[CNT_W-1:0];
            end else if (reg_addr == REG_CONTROL) begin
                if (reg_wdata[F_ARM]) begin
                    st_nxt.meter_armed = 1'b1;
                end
                st_nxt.seq_ext = reg_wdata[F_SEQ_EXT];
            end else if (reg_addr == REG_IRQ_CLEAR) begin
                st_nxt.irq_stat = st_r.irq_stat & ~reg_wdata[IRQ_W-1:0];
            end else if (reg_addr == REG_IRQ_ENABLE) begin
                st_nxt.irq_en = reg_wdata[IRQ_W-1:0];
            end
        end
        // Set wins over a clear in the same cycle
        st_nxt.irq_stat = st_nxt.irq_stat | ev;

        // Register reads, answered one cycle later; unmapped reads zero
        if (reg_rd) begin
            if (reg_addr == REG_STAT_CFG) begin
                st_nxt.rdata = {24'h000000, st_r.stat_cfg};
            end else if (reg_addr == REG_TRIG_CFG) begin
                st_nxt.rdata = {24'h000000, st_r.trig_cfg};
            end else if (reg_addr == REG_PWM_PERIOD) begin
                st_nxt.rdata = {16'h0000, st_r.pwm_period};
            end else if (reg_addr == REG_PWM_HIGH) begin
                st_nxt.rdata = {16'h0000, st_r.pwm_high};
            end else if (reg_addr == REG_CONTROL) begin
                st_nxt.rdata = {30'h0, st_r.seq_ext, st_r.meter_armed};
            end else if (reg_addr == REG_PIN_LEVEL) begin
                // Logical values seen on the pins, inversion applied
                st_nxt.rdata = {30'h0,
                    ~st_r.trig_sync[1] ^ st_r.trig_cfg[F_INV],
                    ~st_r.stat_sync[1] ^ st_r.stat_cfg[F_INV]};
            end else if (reg_addr == REG_IRQ_STATUS) begin
                st_nxt.rdata = {30'h0, st_r.irq_stat};
            end else if (reg_addr == REG_IRQ_ENABLE) begin
                st_nxt.rdata = {30'h0, st_r.irq_en};
            end
        end
    end

    // ------------------------------------------------------------
    // State register; reset restores default functions
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st_r <= '0;
            st_r.stat_cfg <= CFG_RESET;
            st_r.trig_cfg <= CFG_RESET;
            st_r.pwm_period <= PWM_PERIOD_RESET;
            st_r.pwm_high <= PWM_HIGH_RESET;
            st_r.stat_sync <= 2'h3;
            st_r.trig_sync <= 2'h3;
            st_r.stat_drive <= 1'b1;
            st_r.trig_drive <= 1'b1;
            st_r.out_state <= RIOST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = st_r.rdata;
    assign status_pin_out = st_r.stat_drive;
    // Status pin drives unless set to general input; trigger pin drives only as general output or trigger output
    assign status_pin_oe = (st_r.stat_cfg[F_FUNC +: 2] != FUNC_GEN_IN);
    assign trig_pin_oe = (st_r.trig_cfg[F_FUNC +: 2] == FUNC_GEN_OUT) ||
        ((st_r.trig_cfg[F_FUNC +: 2] == FUNC_DEFAULT) && !st_r.trig_cfg[F_DIR]);
    assign trig_pin_out = st_r.trig_drive;
    assign meter_start = st_r.meter_go;
    assign dlog_start = st_r.dlog_go;
    assign seq_start = st_r.seq_go;
    assign irq = |(st_r.irq_stat & st_r.irq_en);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_status_default_level: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (st_r.stat_cfg == 8'h00) && $stable(st_r.stat_cfg) |=> status_pin_out == !$past(output_on))
        else $error("status pin level wrong in default mode");
    a_status_inverted: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (st_r.stat_cfg == 8'h01) && $stable(st_r.stat_cfg) |=> status_pin_out == $past(output_on))
        else $error("inverted status pin level wrong");
    a_gen_true_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (st_r.trig_cfg == 8'h02) && $stable(st_r.trig_cfg) |=> trig_pin_out == 1'b0)
        else $error("general true not driven low");
    a_gen_false_high: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (st_r.trig_cfg == 8'h0a) && $stable(st_r.trig_cfg) |=> trig_pin_out == 1'b1)
        else $error("general false not driven high");
    a_trig_out_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(st_r.out_state == RIOST_LOW) |=> (st_r.out_state == RIOST_LOW) [*8])
        else $error("trigger out low phase too short");
    a_meter_needs_arm: assert property (@(posedge ref_clk) disable iff (!reset_n)
        meter_start |-> $past(st_r.meter_armed))
        else $error("meter started without arm");
    a_seq_needs_ext: assert property (@(posedge ref_clk) disable iff (!reset_n)
        seq_start |-> $past(st_r.seq_ext))
        else $error("sequence started without external source");
    a_start_single: assert property (@(posedge ref_clk) disable iff (!reset_n)
        dlog_start |=> !dlog_start)
        else $error("trigger input raised more than one event");
    a_start_qualified: assert property (@(posedge ref_clk) disable iff (!reset_n)
        dlog_start |-> $past(st_r.in_cnt) == CNT_W'(TRIG_LOW_CYC - 1))
        else $error("trigger accepted before minimum width");

endmodule

// >>> riost_pkg.sv
// Package: constants and types for the rear status and trigger pin logic
package riost_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned TRIG_LOW_US = 30;
    // Least time, so round up; 30 us at 100 MHz is exactly 3000 cycles
    localparam int unsigned TRIG_LOW_CYC = (TRIG_LOW_US * CLK_MHZ + 0) < 1 ? 1 :
        (TRIG_LOW_US * CLK_MHZ);
    localparam int unsigned CNT_W = 16;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] REG_STAT_CFG = 4'h0;
    localparam logic [3:0] REG_TRIG_CFG = 4'h1;
    localparam logic [3:0] REG_PWM_PERIOD = 4'h2;
    localparam logic [3:0] REG_PWM_HIGH = 4'h3;
    localparam logic [3:0] REG_CONTROL = 4'h4;
    localparam logic [3:0] REG_PIN_LEVEL = 4'h5;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h6;
    localparam logic [3:0] REG_IRQ_CLEAR = 4'h7;
    localparam logic [3:0] REG_IRQ_ENABLE = 4'h8;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    // Config word: [0] invert, [2:1] function, [4:3] general output source,
    // [5] trigger direction, [7:6] trigger input target
    localparam int unsigned F_INV = 0;
    localparam int unsigned F_FUNC = 1;
    localparam int unsigned F_SRC = 3;
    localparam int unsigned F_DIR = 5;
    localparam int unsigned F_TGT = 6;
    // Control word: [0] meter arm (write 1), [1] sequence source external
    localparam int unsigned F_ARM = 0;
    localparam int unsigned F_SEQ_EXT = 1;
    // Interrupt bits
    localparam int unsigned IRQ_TRIG_IN = 0;
    localparam int unsigned IRQ_TRIG_OUT = 1;
    localparam int unsigned IRQ_W = 2;

    // ------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] FUNC_DEFAULT = 2'h0;
    localparam logic [1:0] FUNC_GEN_OUT = 2'h1;
    localparam logic [1:0] FUNC_GEN_IN = 2'h2;
    localparam logic [1:0] SRC_ONE = 2'h0;
    localparam logic [1:0] SRC_ZERO = 2'h1;
    localparam logic [1:0] SRC_PWM = 2'h2;
    localparam logic [1:0] TGT_METER = 2'h0;
    localparam logic [1:0] TGT_DLOG = 2'h1;
    localparam logic [1:0] TGT_SEQ = 2'h2;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [CNT_W-1:0] PWM_PERIOD_RESET = 16'h0064;
    localparam logic [CNT_W-1:0] PWM_HIGH_RESET = 16'h0032;

    typedef enum logic [1:0] {RIOST_IDLE, RIOST_LOW, RIOST_HIGH} riost_pulse_e;

endpackage

// >>> riost_pwm.sv
// PWM source: period and active-phase length in clock cycles
`timescale 1ns/1ps
module riost_pwm
    import riost_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [CNT_W-1:0] period,
    input wire logic [CNT_W-1:0] high_len,
    output logic pwm_out
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic out;
    } riost_pwm_s;

    riost_pwm_s st_r;
    riost_pwm_s st_nxt;

    // ------------------------------------------------------------
    // Counter wraps at period; output true while below high length
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (st_r.cnt + 16'h0001 >= period) begin
            st_nxt.cnt = '0;
        end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end
        st_nxt.out = (st_nxt.cnt < high_len);
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pwm_out = st_r.out;

endmodule

// >>> riost_ext_inst.sv
// External instrument model on the trigger pin: pulse source and scope
`timescale 1ns/1ps
module riost_ext_inst
    import riost_pkg::*;
(
    input wire logic ref_clk,
    input wire logic pin_level,
    output logic ext_oe,
    output logic ext_out,
    output int low_len,
    output int pulse_cnt
);
    int run;

    initial begin
        ext_oe = 1'b0;
        ext_out = 1'b1;
        run = 0;
        low_len = 0;
        pulse_cnt = 0;
    end

    // Scope: length of every low phase on the pad, in clock cycles
    always @(posedge ref_clk) begin
        if (pin_level === 1'b0) begin
            run <= run + 1;
        end else begin
            if (run != 0) begin
                low_len <= run;
                pulse_cnt <= pulse_cnt + 1;
            end
            run <= 0;
        end
    end

    // Park the pad at a fixed level, used before inverted input tests
    task automatic hold(input logic lvl);
        @(posedge ref_clk);
        ext_oe <= 1'b1;
        ext_out <= lvl;
    endtask

    // One trigger pulse; active phase held for width cycles
    task automatic pulse(input int width, input logic act);
        @(posedge ref_clk);
        ext_oe <= 1'b1;
        ext_out <= act;
        repeat (width) @(posedge ref_clk); // Active phase no shorter than asked
        ext_out <= ~act;
        repeat (4) @(posedge ref_clk);
        // Releasing an inverted idle would let the pull-up look active
        if (act == 1'b0) begin
            ext_oe <= 1'b0;
        end
    endtask
endmodule

// >>> riost_pins_bench.sv
// Self-checking bench for the rear status and trigger pin logic
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module riost_pins_bench
    import riost_pkg::*;
;
    logic ref_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
    logic output_on = 1'b0, meter_trig = 1'b0, dlog_trig = 1'b0, seq_trig = 1'b0;
    logic st_oe = 1'b0, st_drv = 1'b1, ext_oe, ext_out;
    logic status_pin_out, status_pin_oe, trig_pin_out, trig_pin_oe;
    logic meter_start, dlog_start, seq_start, irq, status_lvl, trig_lvl;
    int error_cnt = 0, checks = 0, cyc = 0, low_len, pulse_cnt;
    int m_cnt = 0, d_cnt = 0, s_cnt = 0;

    // ------------------------------------------------------------
    // Clock, pads and instances
    // ------------------------------------------------------------
    always #5 ref_clk = ~ref_clk;
    // Both pads have a pull-up when nobody drives them
    assign status_lvl = status_pin_oe ? status_pin_out : (st_oe ? st_drv : 1'b1);
    assign trig_lvl = trig_pin_oe ? trig_pin_out : (ext_oe ? ext_out : 1'b1);

    riost_pins u_riost_pins (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .output_on(output_on), .meter_trig(meter_trig), .dlog_trig(dlog_trig),
        .seq_trig(seq_trig), .status_pin_in(status_lvl), .status_pin_out(status_pin_out),
        .status_pin_oe(status_pin_oe), .trig_pin_in(trig_lvl), .trig_pin_out(trig_pin_out),
        .trig_pin_oe(trig_pin_oe), .meter_start(meter_start), .dlog_start(dlog_start),
        .seq_start(seq_start), .irq(irq));
    riost_ext_inst u_riost_ext_inst (.ref_clk(ref_clk), .pin_level(trig_lvl),
        .ext_oe(ext_oe), .ext_out(ext_out), .low_len(low_len), .pulse_cnt(pulse_cnt));

    // Start pulse counters and hang guard, about 40k cycles expected
    always @(posedge ref_clk) begin
        if (meter_start === 1'b1) m_cnt++;
        if (dlog_start === 1'b1) d_cnt++;
        if (seq_start === 1'b1) s_cnt++;
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Bus and stimulus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic fire(input int k);
        @(posedge ref_clk);
        meter_trig <= (k == 0);
        dlog_trig <= (k == 1);
        seq_trig <= (k == 2);
        @(posedge ref_clk);
        {meter_trig, dlog_trig, seq_trig} <= 3'h0;
    endtask

    task automatic st_case(input logic [7:0] cfg, input logic on, input logic exp);
        wr(REG_STAT_CFG, {24'h0, cfg});
        @(posedge ref_clk) output_on <= on;
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK(status_pin_out, exp)
    endtask

    task automatic tin(input logic [7:0] cfg, input logic [1:0] ctl, input int w,
                       input logic act, input int em, input int ed, input int es);
        int m0, d0, s0;
        wr(REG_TRIG_CFG, {24'h0, cfg});
        wr(REG_CONTROL, {30'h0, ctl});
        m0 = m_cnt;
        d0 = d_cnt;
        s0 = s_cnt;
        u_riost_ext_inst.pulse(w, act);
        repeat (20) @(posedge ref_clk);
        `CHK(trig_pin_oe, 1'b0)
        `CHK(m_cnt - m0, em)
        `CHK(d_cnt - d0, ed)
        `CHK(s_cnt - s0, es)
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        `CHK(status_pin_out, 1'b1)
        `CHK(trig_pin_oe, 1'b1)
        rd(REG_STAT_CFG, rv); `CHK(rv, 32'h0)
        rd(REG_TRIG_CFG, rv); `CHK(rv, 32'h0)
        rd(REG_PWM_PERIOD, rv); `CHK(rv, 32'h64)
        rd(REG_PWM_HIGH, rv); `CHK(rv, 32'h32)
        rd(4'hf, rv); `CHK(rv, 32'h0)
    endtask

    // Off and on, plain and inverted, then general output sources
    task automatic t_status_out();
        int lows = 0;
        st_case(8'h00, 1'b1, 1'b0);
        st_case(8'h00, 1'b0, 1'b1);
        st_case(8'h01, 1'b0, 1'b0);
        st_case(8'h01, 1'b1, 1'b1);
        st_case(8'h02, 1'b0, 1'b0);
        st_case(8'h03, 1'b0, 1'b1);
        st_case(8'h0a, 1'b0, 1'b1);
        st_case(8'h0b, 1'b0, 1'b0);
        wr(REG_PWM_PERIOD, 32'ha);
        wr(REG_PWM_HIGH, 32'h4);
        wr(REG_STAT_CFG, 32'h12);
        `CHK(status_pin_oe, 1'b1)
        repeat (20) @(posedge ref_clk);
        repeat (100) begin
            @(posedge ref_clk);
            #1;
            if (status_pin_out === 1'b0) lows++;
        end
        `CHK(lows, 40)
        wr(REG_TRIG_CFG, 32'h2);
        repeat (3) @(posedge ref_clk);
        `CHK(trig_pin_out, 1'b0)
        wr(REG_TRIG_CFG, 32'ha);
        repeat (3) @(posedge ref_clk);
        `CHK(trig_pin_out, 1'b1)
        wr(REG_TRIG_CFG, 32'h0);
    endtask

    // Pad level read back as a logical value, true is low when plain
    task automatic t_status_in();
        @(posedge ref_clk) st_oe <= 1'b1;
        st_drv <= 1'b0;
        wr(REG_STAT_CFG, 32'h4);
        `CHK(status_pin_oe, 1'b0)
        repeat (4) @(posedge ref_clk);
        rd(REG_PIN_LEVEL, rv); `CHK(rv[0], 1'b1)
        @(posedge ref_clk) st_drv <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(REG_PIN_LEVEL, rv); `CHK(rv[0], 1'b0)
        wr(REG_STAT_CFG, 32'h5);
        repeat (4) @(posedge ref_clk);
        rd(REG_PIN_LEVEL, rv); `CHK(rv[0], 1'b1)
    endtask

    // Each source once; a second trigger in recovery must be dropped
    task automatic t_trig_out();
        int p0;
        wr(REG_IRQ_ENABLE, 32'h0);
        wr(REG_IRQ_CLEAR, 32'h3);
        for (int k = 0; k < 3; k++) begin
            p0 = pulse_cnt;
            fire(k);
            repeat (3050) @(posedge ref_clk);
            fire((k + 1) % 3);
            repeat (3100) @(posedge ref_clk);
            `CHK(pulse_cnt - p0, 1)
            `CHK(low_len, int'(TRIG_LOW_CYC))
        end
        `CHK(irq, 1'b0)
        rd(REG_IRQ_STATUS, rv); `CHK(rv, 32'h2)
        wr(REG_IRQ_ENABLE, 32'h2);
        `CHK(irq, 1'b1)
        wr(REG_IRQ_CLEAR, 32'h2);
        `CHK(irq, 1'b0)
    endtask

    // Targets, arming, external source setting, width and inversion
    task automatic t_trig_in();
        tin(8'h60, 2'h0, 3100, 1'b0, 0, 1, 0);
        rd(REG_IRQ_STATUS, rv); `CHK(rv[0], 1'b1)
        tin(8'h60, 2'h0, 2000, 1'b0, 0, 0, 0);
        tin(8'h20, 2'h0, 3100, 1'b0, 0, 0, 0);
        tin(8'h20, 2'h1, 3100, 1'b0, 1, 0, 0);
        tin(8'ha0, 2'h0, 3100, 1'b0, 0, 0, 0);
        tin(8'ha0, 2'h2, 3100, 1'b0, 0, 0, 1);
        u_riost_ext_inst.hold(1'b0);
        tin(8'ha1, 2'h2, 3100, 1'b1, 0, 0, 1);
    endtask

    task automatic wrap_up();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        t_reset();
        t_status_out();
        t_status_in();
        t_trig_out();
        t_trig_in();
        wrap_up();
    end
endmodule
